/* File: logic/pss_pwm_stage_sequencer.sv */
// pwm stage sequencer: gate latch, oscillator, soft start, brown-out and protection
`timescale 1ns/100ps
`default_nettype none

module pss_pwm_stage_sequencer #(
  parameter int unsigned SS_STEP_CYC_P   = pss_pkg::SS_STEP_CYC,
  parameter int unsigned PRE_SHORT_CYC_P = 400000
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              supply_lockout_threshold,
  input  wire logic                              ext_sync_en,
  input  wire pss_pkg::pss_cmp_t                 cmp_in,
  output logic                                   gate_out,
  output logic                                   pfc_sync_out,
  output logic                                   duty_limit_out,
  output logic [pss_pkg::SS_STEP_W-1:0]          soft_start_level,
  output logic                                   duty_feedback_input,
  output pss_pkg::pss_status_t                   status_out
);

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  pss_pkg::pss_cmp_t cmp_s;
  logic              lockout_s;
  logic              ext_sync_en_s;

  pss_sync2 #(
    .W (pss_pkg::CMP_W + 2)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({cmp_in, supply_lockout_threshold, ext_sync_en}),
    .q   ({cmp_s, lockout_s, ext_sync_en_s})
  );

  // ---------------------------------------------------------------
  // brown-out with blanking
  // ---------------------------------------------------------------
  logic                         bo_q;
  logic [pss_pkg::BO_CNT_W-1:0] bo_cnt_q;
  logic                         bo_want;
  logic                         bo_leave;

  // hysteresis: enter below 1.95 V, leave above 2.85 V
  always_comb
  begin
    if (bo_q)
      bo_want = !cmp_s.bus_above_on;
    else
      bo_want = cmp_s.bus_below_bo;
  end

  // state changes only after the new level held for the whole blanking time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bo_q     <= 1'b1;
      bo_cnt_q <= '0;
    end
    else if (bo_want == bo_q)
      bo_cnt_q <= '0;
    else if (bo_cnt_q == pss_pkg::BO_CNT_W'(pss_pkg::BO_BLANK_CYC - 1))
    begin
      bo_q     <= bo_want;
      bo_cnt_q <= '0;
    end
    else
      bo_cnt_q <= bo_cnt_q + 1'b1;
  end

  // one-cycle strobe on the edge that leaves brown-out
  assign bo_leave = bo_q && (bo_want != bo_q)
                    && (bo_cnt_q == pss_pkg::BO_CNT_W'(pss_pkg::BO_BLANK_CYC - 1));

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  pss_pkg::pss_state_t          state_q;
  logic [pss_pkg::SS_CNT_W-1:0] ss_cnt_q;
  logic [pss_pkg::SS_STEP_W-1:0] ss_step_q;
  logic                         prot_q;
  logic [pss_pkg::PS_CNT_W-1:0] ps_cnt_q;
  logic                         ss_tick;

  assign ss_tick = (ss_cnt_q == pss_pkg::SS_CNT_W'(SS_STEP_CYC_P - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_q <= pss_pkg::PSS_OFF;
    else if (bo_q || lockout_s)
      state_q <= pss_pkg::PSS_OFF;
    else
    begin
      case (state_q)
        pss_pkg::PSS_OFF:   state_q <= pss_pkg::PSS_SOFT;
        pss_pkg::PSS_SOFT:
          if (prot_q)
            state_q <= pss_pkg::PSS_FAULT;
          else if (ss_tick && ss_step_q == pss_pkg::SS_STEP_W'(pss_pkg::SS_STEPS - 1))
            state_q <= pss_pkg::PSS_RUN;
        pss_pkg::PSS_RUN:   if (prot_q) state_q <= pss_pkg::PSS_FAULT;
        pss_pkg::PSS_FAULT: state_q <= pss_pkg::PSS_FAULT;
        default:            state_q <= pss_pkg::PSS_OFF;
      endcase
    end
  end

  // soft-start step counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ss_cnt_q  <= '0;
      ss_step_q <= pss_pkg::SS_STEP_RST;
    end
    else if (state_q != pss_pkg::PSS_SOFT)
    begin
      ss_cnt_q  <= '0;
      ss_step_q <= (state_q == pss_pkg::PSS_RUN) ? pss_pkg::SS_STEP_W'(pss_pkg::SS_STEPS) : pss_pkg::SS_STEP_RST;
    end
    else if (ss_tick)
    begin
      ss_cnt_q  <= '0;
      ss_step_q <= ss_step_q + 1'b1;
    end
    else
      ss_cnt_q <= ss_cnt_q + 1'b1;
  end

  // pre-short timer and latched protection; cleared only by leaving brown-out
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prot_q   <= 1'b0;
      ps_cnt_q <= '0;
    end
    else if (bo_leave)
    begin
      prot_q   <= 1'b0;
      ps_cnt_q <= '0;
    end
    else if (bo_q || !cmp_s.cur_short)
      ps_cnt_q <= '0;
    else if (ps_cnt_q == pss_pkg::PS_CNT_W'(PRE_SHORT_CYC_P - 1))
      prot_q <= 1'b1;
    else
      ps_cnt_q <= ps_cnt_q + 1'b1;
  end

  // ---------------------------------------------------------------
  // oscillator and external sync
  // ---------------------------------------------------------------
  logic [pss_pkg::PER_W-1:0] per_q;
  logic                      sync_d1_q;
  logic                      osc_pulse;
  logic                      pfc_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sync_d1_q <= 1'b0;
    else
      sync_d1_q <= cmp_s.sync_clk;
  end

  // sync relies on short off times so rising edges stay clean
  assign osc_pulse = ext_sync_en_s ? (cmp_s.sync_clk && !sync_d1_q)
                                   : (per_q == pss_pkg::PER_W'(pss_pkg::SW_PERIOD_CYC - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      per_q <= '0;
    else if (osc_pulse)
      per_q <= '0;
    // saturates so a slow external sync cannot wrap into a short duty end
    else if (per_q != pss_pkg::PER_W'(pss_pkg::SW_PERIOD_CYC - 1))
      per_q <= per_q + 1'b1;
  end

  // pfc runs at half the pwm rate
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pfc_q <= 1'b0;
    else if (osc_pulse)
      pfc_q <= ~pfc_q;
  end

  // ---------------------------------------------------------------
  // max duty selection
  // ---------------------------------------------------------------
  logic duty_hi;
  logic duty_end;

  // 330 V output shows as bus sense above 2.6 V, which forces 47%
  assign duty_hi  = !cmp_s.sync_high && !cmp_s.bus_above_sel;
  assign duty_end = (per_q >= (duty_hi ? pss_pkg::PER_W'(pss_pkg::DUTY_HI_CYC)
                                       : pss_pkg::PER_W'(pss_pkg::DUTY_LO_CYC)));

  // ---------------------------------------------------------------
  // gate latch with leading-edge blanking
  // ---------------------------------------------------------------
  logic gate_set_reset_latch;
  logic [3:0] leb_q;
  logic cur_trip;
  logic latch_clr;
  logic hard_off;

  assign cur_trip  = cmp_s.cur_cmp && (leb_q == 4'h0);
  assign latch_clr = cmp_s.duty_cmp || (cmp_s.soft_cmp && state_q == pss_pkg::PSS_SOFT)
                     || cur_trip || duty_end;
  assign hard_off  = lockout_s || bo_q || prot_q || cmp_s.pre_short_low
                     || (state_q != pss_pkg::PSS_SOFT && state_q != pss_pkg::PSS_RUN);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gate_set_reset_latch <= pss_pkg::GATE_RST;
    else if (hard_off)
      gate_set_reset_latch <= 1'b0;
    else if (osc_pulse)
      gate_set_reset_latch <= 1'b1;
    else if (latch_clr)
      gate_set_reset_latch <= 1'b0;
  end

  // blanking arms only on a real turn-on; a refused set keeps the sense path live
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      leb_q <= 4'h0;
    else if (osc_pulse && !hard_off)
      leb_q <= 4'(pss_pkg::LEB_CYC);
    else if (leb_q != 4'h0)
      leb_q <= leb_q - 1'b1;
  end

  // clear acts on the output in the same cycle, not one edge later
  assign gate_out = gate_set_reset_latch && !latch_clr && !hard_off;

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pfc_sync_out        <= 1'b0;
      duty_limit_out      <= 1'b0;
      soft_start_level    <= pss_pkg::SS_STEP_RST;
      duty_feedback_input <= 1'b0;
      status_out          <= '0;
    end
    else
    begin
      pfc_sync_out        <= pfc_q;
      duty_limit_out      <= duty_hi;
      soft_start_level    <= ss_step_q;
      duty_feedback_input <= (state_q == pss_pkg::PSS_SOFT);
      status_out          <= '{soft_active:          state_q == pss_pkg::PSS_SOFT,
                               soft_start_level:     ss_step_q,
                               duty_hi_sel:          duty_hi,
                               slope_comp_en:        !cmp_s.sync_high,
                               protect_latched:      prot_q,
                               brown_out_protection: bo_q};
    end
  end

endmodule

`default_nettype wire

/* File: logic/pss_pkg.sv */
// package: constants and carrier types for the pwm stage sequencer
package pss_pkg;

  localparam int unsigned CLK_HZ          = 20000000;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned SW_FREQ_HZ      = 130000;
  localparam int unsigned SW_PERIOD_CYC   = CLK_HZ / SW_FREQ_HZ;
  localparam int unsigned SS_STEP_US      = 800;
  localparam int unsigned SS_STEP_CYC     = SS_STEP_US * (CLK_HZ / 1000000);
  localparam int unsigned SS_TOTAL_MS     = 12;
  localparam int unsigned SS_STEPS        = (SS_TOTAL_MS * 1000) / SS_STEP_US;
  localparam int unsigned BO_BLANK_US     = 50;
  localparam int unsigned BO_BLANK_CYC    = BO_BLANK_US * (CLK_HZ / 1000000);
  localparam int unsigned LEB_NS          = 220;
  localparam int unsigned LEB_CYC         = (LEB_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned DUTY_LO_PCT     = 47;
  localparam int unsigned DUTY_HI_PCT     = 60;
  localparam int unsigned DUTY_LO_CYC     = (SW_PERIOD_CYC * DUTY_LO_PCT) / 100;
  localparam int unsigned DUTY_HI_CYC     = (SW_PERIOD_CYC * DUTY_HI_PCT) / 100;
  localparam int unsigned SYNC_OFF_NS_MAX = 500;

  localparam int unsigned PER_W           = 8;
  localparam int unsigned SS_CNT_W        = 15;
  localparam int unsigned SS_STEP_W       = 4;
  localparam int unsigned BO_CNT_W        = 10;
  localparam int unsigned PS_CNT_W        = 24;

  // reset values
  localparam logic [SS_STEP_W-1:0] SS_STEP_RST = 4'h0;
  localparam logic                 GATE_RST    = 1'b0;

  typedef enum logic [1:0] {
    PSS_OFF,
    PSS_SOFT,
    PSS_RUN,
    PSS_FAULT
  } pss_state_t;

  // synchronised comparator indications
  typedef struct packed {
    logic bus_above_on;   // bus sense > 2.85 V
    logic bus_below_bo;   // bus sense < 1.95 V
    logic bus_above_sel;  // bus sense > 2.6 V
    logic sync_high;      // sync pin > 3.0 V
    logic sync_clk;       // external sync clock
    logic duty_cmp;       // feedback comparator trips
    logic soft_cmp;       // soft-start comparator trips
    logic cur_cmp;        // current above limit
    logic cur_short;      // current sense above 1.0 V
    logic pre_short_low;  // pre-short pin < 0.4 V
  } pss_cmp_t;

  localparam int unsigned CMP_W = $bits(pss_cmp_t);

  typedef struct packed {
    logic                 soft_active;
    logic [SS_STEP_W-1:0] soft_start_level;
    logic                 duty_hi_sel;
    logic                 slope_comp_en;
    logic                 protect_latched;
    logic                 brown_out_protection;
  } pss_status_t;

endpackage

/* File: logic/pss_sync2.sv */
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
`default_nettype none

module pss_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* File: tb/pss_checker.sv */
// checker: port-level assertions for the pwm stage sequencer
`timescale 1ns/100ps
`default_nettype none
module pss_checker #(
  parameter int unsigned SS_STEP_CYC_P   = 20,
  parameter int unsigned PRE_SHORT_CYC_P = 50
) (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          supply_lockout_threshold,
  input wire logic                          ext_sync_en,
  input wire pss_pkg::pss_cmp_t             cmp_in,
  input wire logic                          gate_out,
  input wire logic                          pfc_sync_out,
  input wire logic                          duty_limit_out,
  input wire logic [pss_pkg::SS_STEP_W-1:0] soft_start_level,
  input wire logic                          duty_feedback_input,
  input wire pss_pkg::pss_status_t          status_out
);
  logic                          g_q;
  logic                          ok_q;
  logic [pss_pkg::SS_STEP_W-1:0] lvl_q;
  int unsigned                   on_q;
  int unsigned                   gap_q;
  int unsigned                   sc_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // helpers
  // ----
  always_ff @(posedge clk or posedge rst)
    if (rst) g_q <= 1'b0;
    else g_q <= gate_out;
  always_ff @(posedge clk or posedge rst)
    if (rst) on_q <= 0;
    else on_q <= gate_out ? on_q + 1 : 0;
  always_ff @(posedge clk or posedge rst)
    if (rst) gap_q <= 0;
    else gap_q <= (gate_out && !g_q) ? 1 : gap_q + 1;
  // period is only trusted once a run of internal pulses is under way
  always_ff @(posedge clk or posedge rst)
    if (rst) ok_q <= 1'b0;
    else if (ext_sync_en || supply_lockout_threshold || status_out.brown_out_protection) ok_q <= 1'b0;
    else if (gate_out && !g_q) ok_q <= 1'b1;
  always_ff @(posedge clk or posedge rst)
    if (rst) lvl_q <= '0;
    else lvl_q <= soft_start_level;
  always_ff @(posedge clk or posedge rst)
    if (rst) sc_q <= 0;
    else sc_q <= (soft_start_level != lvl_q) ? 1 : sc_q + 1;
  // ----
  // assertions
  // ----
  lockout_gate_a: assert property (
    supply_lockout_threshold [*4] |-> !gate_out) else $error("gate high under lockout");
  preshort_gate_a: assert property (
    cmp_in.pre_short_low [*4] |-> !gate_out) else $error("gate high with pre-short low");
  brownout_gate_a: assert property (
    status_out.brown_out_protection |-> !gate_out) else $error("gate high in brown-out");
  protect_gate_a: assert property (
    status_out.protect_latched |-> !gate_out) else $error("gate high while protected");
  duty_width_a: assert property (
    gate_out && on_q >= 72 |-> duty_limit_out && on_q < 92) else $error("pulse over max duty");
  duty_sel_a: assert property (
    $stable({cmp_in.sync_high, cmp_in.bus_above_sel}) [*8]
    |-> duty_limit_out == !(cmp_in.sync_high || cmp_in.bus_above_sel)) else $error("max duty select wrong");
  slope_sel_a: assert property (
    $stable(cmp_in.sync_high) [*8] |-> status_out.slope_comp_en == !cmp_in.sync_high)
    else $error("slope enable wrong");
  osc_period_a: assert property (
    gate_out && !g_q && ok_q && !ext_sync_en |-> gap_q % pss_pkg::SW_PERIOD_CYC == 0)
    else $error("switching period wrong");
  ss_step_a: assert property (
    soft_start_level != lvl_q && soft_start_level > 4'h1
    |-> sc_q == SS_STEP_CYC_P && soft_start_level == lvl_q + 4'h1) else $error("soft-start step wrong");
endmodule
bind pss_pwm_stage_sequencer pss_checker #(.SS_STEP_CYC_P(SS_STEP_CYC_P), .PRE_SHORT_CYC_P(PRE_SHORT_CYC_P)) chk_u (
  .clk(clk), .rst(rst), .supply_lockout_threshold(supply_lockout_threshold), .ext_sync_en(ext_sync_en),
  .cmp_in(cmp_in), .gate_out(gate_out), .pfc_sync_out(pfc_sync_out), .duty_limit_out(duty_limit_out),
  .soft_start_level(soft_start_level), .duty_feedback_input(duty_feedback_input), .status_out(status_out));
`default_nettype wire

/* File: tb/pss_partner.sv */
// partner: power switch current ramp and external sync source
`timescale 1ns/100ps
`default_nettype none
module pss_partner #(
  parameter int unsigned SYNC_PER = 100
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       gate,
  input  wire logic [7:0] trip_cyc,
  output logic            cur_trip,
  output logic            sync_clk
);
  logic [7:0]  ramp_q;
  int unsigned sp_q;
  // current only ramps while the switch conducts
  always_ff @(posedge clk or posedge rst)
    if (rst) ramp_q <= 8'h00;
    else ramp_q <= gate ? ramp_q + 8'h01 : 8'h00;
  assign cur_trip = gate && (ramp_q >= trip_cyc);
  // low phase of 8 cycles keeps the off time at 400 ns
  always_ff @(posedge clk or posedge rst)
    if (rst) sp_q <= 0;
    else sp_q <= (sp_q == SYNC_PER - 1) ? 0 : sp_q + 1;
  always_ff @(posedge clk or posedge rst)
    if (rst) sync_clk <= 1'b0;
    else sync_clk <= (sp_q < SYNC_PER - 8);
endmodule
`default_nettype wire

/* File: tb/pss_pwm_stage_sequencer_bench.sv */
// testbench: self-checking bench for the pwm stage sequencer
`timescale 1ns/100ps
`default_nettype none
module pss_pwm_stage_sequencer_bench;
  logic clk, rst, lock, xsync, gate, pfc, dlim, dfb, cur_trip, sclk, pf_a, pf_b;
  logic [pss_pkg::SS_STEP_W-1:0] lvl;
  logic [7:0]                    trip;
  pss_pkg::pss_cmp_t             cmp_d, cmp_in;
  pss_pkg::pss_status_t          st;
  int                            errors, n_tests, w, per, hi, k;
  pss_pwm_stage_sequencer #(.SS_STEP_CYC_P(20), .PRE_SHORT_CYC_P(50)) dut_u (.clk(clk), .rst(rst),
    .supply_lockout_threshold(lock), .ext_sync_en(xsync), .cmp_in(cmp_in), .gate_out(gate), .pfc_sync_out(pfc),
    .duty_limit_out(dlim), .soft_start_level(lvl), .duty_feedback_input(dfb), .status_out(st));
  pss_partner prt_u (.clk(clk), .rst(rst), .gate(gate), .trip_cyc(trip), .cur_trip(cur_trip), .sync_clk(sclk));
  always_comb
  begin
    cmp_in = cmp_d;
    cmp_in.cur_cmp = cur_trip;
    cmp_in.sync_clk = sclk;
  end
  initial clk = 1'b0;
  always #25 clk = ~clk;
  // ----
  // tasks
  // ----
  function automatic int dmax(input logic sh, input logic sel);
    return (sh || sel) ? pss_pkg::DUTY_LO_CYC : pss_pkg::DUTY_HI_CYC;
  endfunction
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hiv);
    n_tests++;
    if (got < lo || got > hiv)
    begin
      errors++;
      $display("BAD %0t count %0d not in %0d..%0d", $time, got, lo, hiv);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic watch(input int n, output int h);
    h = 0;
    repeat (n) @(negedge clk) h += (gate === 1'b1);
    cyc(1);
  endtask
  // one pulse width and the rise-to-rise period, bounded at 600 cycles
  task automatic meas(output int wd, output int p);
    int i;
    i = 0;
    for (; i < 600 && gate !== 1'b0; i++) @(negedge clk);
    for (; i < 600 && gate !== 1'b1; i++) @(negedge clk);
    pf_a = pfc;
    for (wd = 0; i < 600 && gate === 1'b1; i++, wd++) @(negedge clk);
    for (p = wd; i < 600 && gate !== 1'b1; i++, p++) @(negedge clk);
    pf_b = pfc;
    if (i >= 600)
    begin
      wd = -1;
      p  = -1;
    end
    cyc(1);
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    void'($urandom(92));
    {errors, n_tests} = 0;
    {rst, lock, xsync, trip} = {3'b100, 8'hff};
    cmp_d = '0;
    cmp_d.bus_below_bo = 1'b1;
    cmp_d.bus_above_sel = 1'b1;
    cyc(6);
    rst = 1'b0;
    {cmp_d.bus_below_bo, cmp_d.bus_above_on} = 2'b01;
    cyc(1100);
    chk_bit(st.soft_active, 1'b1);
    chk_bit(dfb, 1'b1);
    cmp_d.soft_cmp = 1'b1;
    cyc(3);
    watch(160, hi);
    chk_rng(hi, 0, 0);
    cmp_d.soft_cmp = 1'b0;
    cyc(250);
    chk_bit(lvl === 4'(pss_pkg::SS_STEPS), 1'b1);
    chk_bit(st.soft_start_level === 4'(pss_pkg::SS_STEPS), 1'b1);
    chk_bit(st.soft_active, 1'b0);
    chk_bit(dfb, 1'b0);
    for (k = 0; k < 4; k++)
    begin
      {cmp_d.sync_high, cmp_d.bus_above_sel} = k[1:0];
      cyc(10);
      meas(w, per);
      meas(w, per);
      chk_bit(dlim, dmax(k[1], k[0]) == pss_pkg::DUTY_HI_CYC);
      chk_bit(st.duty_hi_sel, dmax(k[1], k[0]) == pss_pkg::DUTY_HI_CYC);
      chk_bit(st.slope_comp_en, !k[1]);
      chk_rng(w, dmax(k[1], k[0]) - 3, dmax(k[1], k[0]) + 1);
      chk_rng(per, pss_pkg::SW_PERIOD_CYC, pss_pkg::SW_PERIOD_CYC);
    end
    trip = 8'(10 + $urandom % 31);
    meas(w, per);
    chk_rng(w, int'(trip) + 1, int'(trip) + 4);
    trip = 8'h00;
    meas(w, per);
    chk_rng(w, pss_pkg::LEB_CYC, pss_pkg::LEB_CYC + 3);
    trip = 8'hff;
    for (k = 0; k < 3; k++)
    begin
      {lock, cmp_d.duty_cmp, cmp_d.pre_short_low} = 3'b100 >> k;
      cyc(4);
      watch(200, hi);
      chk_rng(hi, 0, 0);
      {lock, cmp_d.duty_cmp, cmp_d.pre_short_low} = 3'b000;
      meas(w, per);
      chk_rng(w, 1, pss_pkg::DUTY_LO_CYC + 1);
    end
    xsync = 1'b1;
    cyc(10);
    meas(w, per);
    meas(w, per);
    chk_rng(per, 100, 100);
    chk_bit(pf_b, !pf_a);
    cmp_d.cur_short = 1'b1;
    cyc(80);
    cmp_d.cur_short = 1'b0;
    cyc(5);
    chk_bit(st.protect_latched, 1'b1);
    watch(300, hi);
    chk_rng(hi, 0, 0);
    {cmp_d.bus_below_bo, cmp_d.bus_above_on} = 2'b10;
    cyc(200 + $urandom % 700);
    {cmp_d.bus_below_bo, cmp_d.bus_above_on} = 2'b01;
    cyc(5);
    chk_bit(st.brown_out_protection, 1'b0);
    {xsync, cmp_d.bus_below_bo, cmp_d.bus_above_on} = 3'b010;
    cyc(1010);
    chk_bit(st.brown_out_protection, 1'b1);
    chk_bit(st.protect_latched, 1'b1);
    {cmp_d.bus_below_bo, cmp_d.bus_above_on} = 2'b01;
    cyc(1060);
    chk_bit(st.protect_latched, 1'b0);
    chk_bit(st.soft_active, 1'b1);
    chk_rng(int'(lvl), 1, 4);
    meas(w, per);
    chk_rng(w, 1, pss_pkg::DUTY_LO_CYC + 1);
    tally_and_finish();
  end
  initial
  begin
    #1000000;
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
